// ### inc/cfh_defines.vh
`ifndef CFH_DEFINES_VH
`define CFH_DEFINES_VH

// register byte addresses on the apb side
`define CFH_ADDR_CTRL       8'h00
`define CFH_ADDR_ADDR       8'h04
`define CFH_ADDR_WDATA      8'h08
`define CFH_ADDR_CMD        8'h0C
`define CFH_ADDR_STATUS     8'h10
`define CFH_ADDR_RDATA      8'h14

// control register fields
`define CFH_CTRL_SPACE_LO   0
`define CFH_CTRL_SPACE_HI   1
`define CFH_CTRL_DISK       2
`define CFH_CTRL_BYTE       3
`define CFH_CTRL_RESTART    4
`define CFH_CTRL_CLRSR      5

// access space codes
`define CFH_SPACE_ATTR      2'h0
`define CFH_SPACE_IO        2'h1
`define CFH_SPACE_MEM       2'h2

// command register fields
`define CFH_CMD_WR          0
`define CFH_CMD_LO          1
`define CFH_CMD_HI          2

// status register fields
`define CFH_ST_BUSY         0
`define CFH_ST_REFUSED      1
`define CFH_ST_DISK         2
`define CFH_ST_READY        3
`define CFH_ST_SRST         4
`define CFH_ST_LEVEL        5
`define CFH_ST_MAP_LO       8
`define CFH_ST_MAP_HI       13

// card configuration option register and its fields
`define CFH_COR_ADDR        11'h200
`define CFH_COR_RESET       8'h00
`define CFH_COR_SRST        7
`define CFH_COR_LEVEL       6
`define CFH_COR_MAP_HI      5
`define CFH_COR_MAP_LO      0
`define CFH_MAP_MEM         6'h00
`define CFH_MAP_CONTIG      6'h01
`define CFH_MAP_PRIMARY     6'h02
`define CFH_MAP_SECONDARY   6'h03

// disk emulation task file addresses
`define CFH_IDE_DATA        3'h0
`define CFH_IDE_ALT         3'h6

// bus timing, nanoseconds and clock period
`define CFH_CLK_NS          10
`define CFH_SETUP_NS        30
`define CFH_STROBE_NS       165
`define CFH_HOLD_NS         20
`define CFH_SETUP_CYC       ((`CFH_SETUP_NS + `CFH_CLK_NS - 1) / `CFH_CLK_NS)
`define CFH_STROBE_CYC      ((`CFH_STROBE_NS + `CFH_CLK_NS - 1) / `CFH_CLK_NS)
`define CFH_HOLD_CYC        ((`CFH_HOLD_NS + `CFH_CLK_NS - 1) / `CFH_CLK_NS)

// power-up hold time
`define CFH_PWRUP_US        1000
`define CFH_PWRUP_CYC       (`CFH_PWRUP_US * 1000 / `CFH_CLK_NS)

`endif

// ### rtl/cfh_lane.v
`timescale 1ns/1ns
`default_nettype none
module cfh_lane (
  input  wire        i_use_lo,
  input  wire        i_use_hi,
  input  wire [15:0] i_wdata,
  input  wire [15:0] i_pin_data,
  output reg  [15:0] o_pin_data,
  output reg  [15:0] o_rdata
);

  // steer bytes between the host word and the two card lanes
  always @* begin
    o_pin_data = 16'h0000;
    o_rdata    = 16'h0000;
    if (i_use_lo && i_use_hi) begin
      o_pin_data = i_wdata;
      o_rdata    = i_pin_data;
    end else if (i_use_lo) begin
      o_pin_data = {8'h00, i_wdata[7:0]};
      o_rdata    = {8'h00, i_pin_data[7:0]};
    end else if (i_use_hi) begin
      o_pin_data = {i_wdata[7:0], 8'h00};
      o_rdata    = {8'h00, i_pin_data[15:8]};
    end
  end

endmodule // cfh_lane
`default_nettype wire

// ### rtl/cfh_pwrup.v
`timescale 1ns/1ns
`default_nettype none
`include "cfh_defines.vh"
module cfh_pwrup #(
  parameter PWRUP_CYCLES = `CFH_PWRUP_CYC
) (
  input  wire i_sys_clk,
  input  wire i_sys_rst,
  input  wire i_restart,
  input  wire i_disk_req,
  output wire o_busy,
  output wire o_card_reset,
  output wire o_strap_oe_low,
  output wire o_disk_mode
);

  reg [19:0] cnt_r;
  reg        busy_r;
  reg        disk_r;

  // count the power-up period; the strap is caught only when it ends
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt_r  <= 20'h00000;
      busy_r <= 1'b1;
      disk_r <= 1'b0;
    end else if (i_restart) begin
      cnt_r  <= 20'h00000;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r == PWRUP_CYCLES[19:0] - 20'h00001) begin
        busy_r <= 1'b0;
        disk_r <= i_disk_req;
      end else begin
        cnt_r <= cnt_r + 20'h00001;
      end
    end
  end

  assign o_busy         = busy_r;
  assign o_card_reset   = busy_r;
  assign o_strap_oe_low = busy_r & i_disk_req;
  assign o_disk_mode    = disk_r;

endmodule // cfh_pwrup
`default_nettype wire

// ### rtl/cfh_ctrl.v
// Behaviour
// - attribute cycles drive space select low
// - i/o mode uses io strobes, oe/we high
// - memory mode: space select high, same steering
// - hold oe low at power-up for disk mode
`timescale 1ns/1ns
`default_nettype none
`include "cfh_defines.vh"
module cfh_ctrl #(
  parameter PWRUP_CYCLES = `CFH_PWRUP_CYC
) (
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  output reg  [10:0] o_card_addr,
  output reg         o_low_lane_enable_n,
  output reg         o_high_lane_enable_n,
  output reg         o_attr_space_n,
  output reg         o_mem_oe_n,
  output reg         o_mem_we_n,
  output reg         o_io_read_strobe_n,
  output reg         o_io_write_strobe_n,
  output wire        o_card_reset,
  input  wire [15:0] i_card_data,
  output reg  [15:0] o_card_data,
  output reg         o_card_data_oe_n
);

  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_SETUP  = 4'b0010;
  localparam [3:0] ST_STROBE = 4'b0100;
  localparam [3:0] ST_HOLD   = 4'b1000;

  // phase counter loads, cut to the counter width where they are used
  localparam [31:0] SETUP_LD  = `CFH_SETUP_CYC - 1;
  localparam [31:0] STROBE_LD = `CFH_STROBE_CYC - 1;
  localparam [31:0] HOLD_LD   = `CFH_HOLD_CYC - 1;

  reg [3:0]  state_r;
  reg [5:0]  ctrl_r;
  reg [10:0] addr_r;
  reg [15:0] wdata_r;
  reg [15:0] rdata_r;
  reg [7:0]  cor_r;
  reg        refused_r;
  reg        srst_seen_r;
  reg [7:0]  tcnt_r;
  reg        wr_r;
  reg        use_lo_r;
  reg        use_hi_r;
  reg [1:0]  space_r;

  wire        pu_busy;
  wire        strap_low;
  wire        disk_mode;
  wire [15:0] lane_out;
  wire [15:0] lane_in;
  wire        apb_wr;
  wire        cmd_wr;
  wire        cmd_lo;
  wire        cmd_hi;
  wire        cmd_bad;
  wire        cor_hit;
  wire        srst_wr;
  wire [1:0]  space;

  // one apb register decode, used only for the error response on reads and writes
  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a == `CFH_ADDR_CTRL)   || (a == `CFH_ADDR_ADDR) ||
                   (a == `CFH_ADDR_WDATA)  || (a == `CFH_ADDR_CMD)  ||
                   (a == `CFH_ADDR_STATUS) || (a == `CFH_ADDR_RDATA);
    end
  endfunction

  // check a requested card cycle against the current card mode
  function refuse;
    input       disk;
    input [1:0] spc;
    input [5:0] map;
    input       lo;
    input       hi;
    input [10:0] a;
    begin
      refuse = 1'b0;
      if (!lo && !hi)
        refuse = 1'b1;
      else if (disk) begin
        if (spc == `CFH_SPACE_ATTR)
          refuse = 1'b1;
        else if (lo && hi)
          refuse = 1'b1;
        else if (hi && a[2:0] != `CFH_IDE_ALT)
          refuse = 1'b1;
      end else if (spc == `CFH_SPACE_ATTR) begin
        if (!lo || a[0])
          refuse = 1'b1;
      end else if (spc == `CFH_SPACE_MEM) begin
        if (map != `CFH_MAP_MEM)
          refuse = 1'b1;
      end else if (spc == `CFH_SPACE_IO) begin
        if (map == `CFH_MAP_MEM)
          refuse = 1'b1;
      end else
        refuse = 1'b1;
    end
  endfunction

  // apb slave: zero wait states, error on unmapped addresses
  assign apb_wr    = i_psel & i_penable & i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_known(i_paddr);
  assign cmd_wr    = apb_wr & (i_paddr == `CFH_ADDR_CMD);
  assign cmd_lo    = i_pwdata[`CFH_CMD_LO];
  assign cmd_hi    = i_pwdata[`CFH_CMD_HI];
  assign space     = ctrl_r[`CFH_CTRL_SPACE_HI:`CFH_CTRL_SPACE_LO];
  assign cmd_bad   = refuse(disk_mode, space, cor_r[`CFH_COR_MAP_HI:`CFH_COR_MAP_LO],
                            cmd_lo, cmd_hi, addr_r);
  assign cor_hit   = (space_r == `CFH_SPACE_ATTR) && (o_card_addr == `CFH_COR_ADDR);
  assign srst_wr   = (state_r == ST_HOLD) && (tcnt_r == 8'h00) && wr_r && cor_hit &&
                     wdata_r[`CFH_COR_SRST];

  // apb read mux
  always @* begin
    o_prdata = 32'h00000000;
    case (i_paddr)
      `CFH_ADDR_CTRL:   o_prdata = {26'h0000000, ctrl_r};
      `CFH_ADDR_ADDR:   o_prdata = {21'h000000, addr_r};
      `CFH_ADDR_WDATA:  o_prdata = {16'h0000, wdata_r};
      `CFH_ADDR_STATUS: o_prdata = {18'h00000, cor_r[`CFH_COR_MAP_HI:`CFH_COR_MAP_LO],
                                    2'h0, cor_r[`CFH_COR_LEVEL], srst_seen_r,
                                    ~pu_busy, disk_mode, refused_r,
                                    (state_r != ST_IDLE) | pu_busy};
      `CFH_ADDR_RDATA:  o_prdata = {16'h0000, rdata_r};
      default:          o_prdata = 32'h00000000;
    endcase
  end

  // software registers; the restart bit is a self-clearing pulse
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_r  <= 6'h00;
      addr_r  <= 11'h000;
      wdata_r <= 16'h0000;
    end else begin
      ctrl_r[`CFH_CTRL_RESTART] <= 1'b0;
      ctrl_r[`CFH_CTRL_CLRSR]   <= 1'b0;
      if (apb_wr && i_paddr == `CFH_ADDR_CTRL)
        ctrl_r <= i_pwdata[5:0];
      if (apb_wr && i_paddr == `CFH_ADDR_ADDR)
        addr_r <= i_pwdata[10:0];
      if (apb_wr && i_paddr == `CFH_ADDR_WDATA)
        wdata_r <= i_pwdata[15:0];
    end
  end

  // shadow of the card option register, cleared on every power-on sequence
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cor_r <= `CFH_COR_RESET;
    end else if (pu_busy) begin
      cor_r <= `CFH_COR_RESET;
    end else if ((state_r == ST_HOLD) && (tcnt_r == 8'h00) && wr_r && cor_hit) begin
      cor_r <= wdata_r[7:0];
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      refused_r   <= 1'b0;
      srst_seen_r <= 1'b0;
    end else begin
      if (cmd_wr && state_r == ST_IDLE && !pu_busy && !cmd_bad)
        refused_r <= 1'b0;
      if (cmd_wr && (state_r != ST_IDLE || pu_busy || cmd_bad))
        refused_r <= 1'b1;
      if (ctrl_r[`CFH_CTRL_CLRSR])
        srst_seen_r <= 1'b0;
      if (srst_wr)
        srst_seen_r <= 1'b1;
    end
  end

  // card cycle sequencer: setup, strobe, hold
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_r  <= ST_IDLE;
      tcnt_r   <= 8'h00;
      wr_r     <= 1'b0;
      use_lo_r <= 1'b0;
      use_hi_r <= 1'b0;
      space_r  <= `CFH_SPACE_ATTR;
      rdata_r  <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_wr && !pu_busy && !cmd_bad) begin
            state_r  <= ST_SETUP;
            tcnt_r   <= SETUP_LD[7:0];
            wr_r     <= i_pwdata[`CFH_CMD_WR];
            space_r  <= space;
            use_hi_r <= cmd_hi & ~(cmd_lo & ~disk_mode & (space == `CFH_SPACE_ATTR));
            use_lo_r <= cmd_lo;
            if (disk_mode && cmd_lo && addr_r[2:0] == `CFH_IDE_DATA &&
                !ctrl_r[`CFH_CTRL_BYTE])
              use_hi_r <= 1'b1;
            if (disk_mode && cmd_hi) begin
              use_lo_r <= 1'b1;
              use_hi_r <= 1'b0;
            end
          end
        end
        ST_SETUP: begin
          if (tcnt_r == 8'h00) begin
            state_r <= ST_STROBE;
            tcnt_r  <= STROBE_LD[7:0];
          end else
            tcnt_r <= tcnt_r - 8'h01;
        end
        ST_STROBE: begin
          if (tcnt_r == 8'h00) begin
            state_r <= ST_HOLD;
            tcnt_r  <= HOLD_LD[7:0];
            if (!wr_r)
              rdata_r <= lane_in;
          end else
            tcnt_r <= tcnt_r - 8'h01;
        end
        ST_HOLD: begin
          if (tcnt_r == 8'h00)
            state_r <= ST_IDLE;
          else
            tcnt_r <= tcnt_r - 8'h01;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // card pins, registered; strobes active only in the strobe state, except oe held low at disk power-up and in disk mode
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_card_addr          <= 11'h000;
      o_low_lane_enable_n  <= 1'b1;
      o_high_lane_enable_n <= 1'b1;
      o_attr_space_n       <= 1'b1;
      o_mem_oe_n           <= 1'b1;
      o_mem_we_n           <= 1'b1;
      o_io_read_strobe_n   <= 1'b1;
      o_io_write_strobe_n  <= 1'b1;
      o_card_data          <= 16'h0000;
      o_card_data_oe_n     <= 1'b1;
    end else begin
      o_io_read_strobe_n  <= 1'b1;
      o_io_write_strobe_n <= 1'b1;
      o_mem_we_n          <= 1'b1;
      o_mem_oe_n          <= ~(strap_low | disk_mode);
      if (state_r == ST_IDLE && !(cmd_wr && !pu_busy && !cmd_bad)) begin
        o_low_lane_enable_n  <= 1'b1;
        o_high_lane_enable_n <= 1'b1;
        o_card_data_oe_n     <= 1'b1;
      end else if (state_r == ST_IDLE) begin
        o_card_addr          <= addr_r;
        o_low_lane_enable_n  <= ~cmd_lo;
        o_high_lane_enable_n <= ~cmd_hi;
        o_attr_space_n       <= disk_mode | (space == `CFH_SPACE_MEM);
        o_card_data_oe_n     <= 1'b1;
      end else if (state_r == ST_HOLD && tcnt_r == 8'h00) begin
        o_low_lane_enable_n  <= 1'b1;
        o_high_lane_enable_n <= 1'b1;
        o_card_data_oe_n     <= 1'b1;
      end else begin
        o_card_data      <= lane_out;
        o_card_data_oe_n <= ~wr_r;
        if (state_r == ST_STROBE && !(tcnt_r == 8'h00)) begin
          if (disk_mode || space_r == `CFH_SPACE_IO) begin
            o_io_read_strobe_n  <= wr_r;
            o_io_write_strobe_n <= ~wr_r;
          end else begin
            o_mem_oe_n <= wr_r;
            o_mem_we_n <= ~wr_r;
          end
        end
      end
    end
  end

  // byte lane steering
  cfh_lane u_lane (
    .i_use_lo   (use_lo_r),
    .i_use_hi   (use_hi_r),
    .i_wdata    (wdata_r),
    .i_pin_data (i_card_data),
    .o_pin_data (lane_out),
    .o_rdata    (lane_in)
  );

  // power-on sequence, rerun after a soft reset write
  cfh_pwrup #(
    .PWRUP_CYCLES (PWRUP_CYCLES)
  ) u_pwrup (
    .i_sys_clk      (i_sys_clk),
    .i_sys_rst      (i_sys_rst),
    .i_restart      (ctrl_r[`CFH_CTRL_RESTART] | srst_wr),
    .i_disk_req     (ctrl_r[`CFH_CTRL_DISK]),
    .o_busy         (pu_busy),
    .o_card_reset   (o_card_reset),
    .o_strap_oe_low (strap_low),
    .o_disk_mode    (disk_mode)
  );

endmodule // cfh_ctrl
`default_nettype wire

// ### dv/cfh_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module cfh_ctrl_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [7:0]  i_paddr,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [10:0] o_card_addr,
  input wire logic        o_low_lane_enable_n,
  input wire logic        o_high_lane_enable_n,
  input wire logic        o_attr_space_n,
  input wire logic        o_mem_oe_n,
  input wire logic        o_mem_we_n,
  input wire logic        o_io_read_strobe_n,
  input wire logic        o_io_write_strobe_n,
  input wire logic        o_card_reset,
  input wire logic [15:0] o_card_data,
  input wire logic        o_card_data_oe_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // combined strobes, high while no write strobe or io read strobe is active
  wire wr_n  = o_io_write_strobe_n & o_mem_we_n;
  wire any_n = wr_n & o_io_read_strobe_n;
  wire sel   = !o_low_lane_enable_n || !o_high_lane_enable_n;
  // shorthands for io strobes, attribute and disk cycles, apb decode
  wire io_n     = o_io_read_strobe_n & o_io_write_strobe_n;
  wire attr_cyc = !o_attr_space_n && !o_card_reset && sel && !(o_mem_oe_n && o_mem_we_n);
  wire disk_cyc = !o_mem_oe_n && !io_n;
  wire one_lane = o_low_lane_enable_n ^ o_high_lane_enable_n;
  wire alt_ok   = o_high_lane_enable_n || o_card_addr[2:0] == 3'h6;
  wire apb_map  = i_paddr[1:0] == 2'h0 && i_paddr <= 8'h14;
  // read strobe: sixteen cycles low, then released
  sequence s_rd_low8;
    !o_io_read_strobe_n [*8];
  endsequence
  sequence s_rd_16;
    s_rd_low8 ##1 s_rd_low8 ##1 o_io_read_strobe_n;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) i_sys_rst |=> o_card_reset && any_n && !sel)
    else $error("card pins not idle after reset");
  a_apb_answer: assert property (i_psel && i_penable |-> o_pready && o_pslverr == !apb_map)
    else $error("apb answer wrong");
  a_strobe_len: assert property ($fell(o_io_read_strobe_n) |-> s_rd_16)
    else $error("read strobe length wrong");
  a_setup_sel: assert property ($fell(any_n) |-> $past(sel, 3))
    else $error("strobe without enable setup");
  a_wdata_hold: assert property ($rose(wr_n) |-> !o_card_data_oe_n && $stable(o_card_data))
    else $error("write data not held past strobe");
  a_rd_no_fight: assert property (!o_io_read_strobe_n |-> o_card_data_oe_n)
    else $error("host drives data during read");
  a_standby_idle: assert property (!sel |-> o_card_data_oe_n && any_n)
    else $error("activity while both enables high");
  a_io_no_mem: assert property (!io_n && !o_attr_space_n |-> o_mem_oe_n && o_mem_we_n)
    else $error("io cycle with memory enables low");
  a_attr_even: assert property (attr_cyc |-> !o_low_lane_enable_n && !o_card_addr[0])
    else $error("attribute cycle not even low lane");
  a_disk_lanes: assert property (disk_cyc |-> one_lane && alt_ok)
    else $error("disk mode enables invalid");
endmodule // cfh_ctrl_monitor
`default_nettype wire

// ### dv/cfh_card_model.sv
`timescale 1ns/1ns
`default_nettype none
module cfh_card_model (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [10:0] i_addr,
  input wire logic        i_lo_n,
  input wire logic        i_hi_n,
  input wire logic        i_attr_n,
  input wire logic        i_oe_n,
  input wire logic        i_we_n,
  input wire logic        i_rd_n,
  input wire logic        i_wr_n,
  input wire logic [15:0] i_wdata,
  output logic     [15:0] o_rdata
);
  logic [7:0]  cor_r = 8'h00;
  logic [7:0]  tf_r [0:15];
  logic [15:0] junk_r = 16'hA5C3;
  logic        disk_r = 1'b0;
  wire  [3:0]  ev = {i_addr[3:1], 1'b0};
  wire  [3:0]  lo_ix = (i_hi_n && i_addr[0]) ? ev + 4'h1 : ev;
  // released lines show a changing pattern
  always @(posedge i_clk) junk_r <= ~junk_r;
  // hard reset clears config, strap sampled at its end
  always @(posedge i_reset) cor_r = 8'h00;
  always @(negedge i_reset) disk_r = !i_oe_n;
  task automatic wr(input logic attr);
    if (!i_lo_n || !i_hi_n) begin
      if (attr) begin
        if (!disk_r && !i_lo_n && !i_addr[0] && i_addr == 11'h200)
          cor_r = i_wdata[7] ? 8'h80 : i_wdata[7:0];
      end else if (disk_r && i_lo_n) tf_r[14] = i_wdata[7:0];
      else begin
        if (!i_lo_n) tf_r[lo_ix] = i_wdata[7:0];
        if (!i_hi_n) tf_r[ev + 4'h1] = i_wdata[15:8];
        if (disk_r && !i_lo_n && i_addr[2:0] == 3'h0) tf_r[1] = i_wdata[15:8];
      end
    end
  endtask
  // writes land on the release of the strobe
  always @(posedge i_wr_n) wr(1'b0);
  always @(posedge i_we_n) wr(!i_attr_n);
  // read drive only while enabled and strobed
  always @* begin
    o_rdata = junk_r;
    if ((!i_lo_n || !i_hi_n) && (!i_rd_n || (!i_oe_n && !disk_r))) begin
      if (!i_attr_n && i_rd_n) begin
        if (!i_lo_n && !i_addr[0]) o_rdata[7:0] = (i_addr == 11'h200) ? cor_r : 8'h00;
      end else begin
        if (!i_lo_n) o_rdata[7:0] = tf_r[lo_ix];
        if (!i_hi_n) o_rdata[15:8] = tf_r[ev + 4'h1];
        if (disk_r && !i_lo_n && i_addr[2:0] == 3'h0) o_rdata[15:8] = tf_r[1];
        if (disk_r && i_lo_n) o_rdata[7:0] = tf_r[14];
      end
    end
  end
endmodule // cfh_card_model
`default_nettype wire

// ### dv/cfh_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cfh_ctrl_tb;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sl;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q, ctrl_v = 32'h0;
  logic        rdy, serr, loe, hie, asp, oe, we, io_read_strobe_n, io_write_strobe_n, crst, doe;
  logic [10:0] ca;
  logic [15:0] cdo, mdo;
  wire  [15:0] bus = doe ? mdo : cdo;
  int          err_count = 0, num_checks = 0, cyc_n = 0;
  always #5 clk = ~clk;
  cfh_ctrl #(.PWRUP_CYCLES(16)) i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(serr), .o_card_addr(ca), .o_low_lane_enable_n(loe),
    .o_high_lane_enable_n(hie), .o_attr_space_n(asp), .o_mem_oe_n(oe), .o_mem_we_n(we),
    .o_io_read_strobe_n(io_read_strobe_n), .o_io_write_strobe_n(io_write_strobe_n), .o_card_reset(crst),
    .i_card_data(bus), .o_card_data(cdo), .o_card_data_oe_n(doe));
  cfh_card_model i_card (.i_clk(clk), .i_reset(crst), .i_addr(ca), .i_lo_n(loe), .i_hi_n(hie),
    .i_attr_n(asp), .i_oe_n(oe), .i_we_n(we), .i_rd_n(io_read_strobe_n), .i_wr_n(io_write_strobe_n), .i_wdata(bus),
    .o_rdata(mdo));
  task automatic apb(input [7:0] a, input w, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pa <= a; pwr <= w; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = prd; sl = serr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic chk(input [31:0] g, input [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // wait until not busy and ready
  task automatic idle;
    do apb(8'h10, 1'b0, 32'h0); while (q[0] !== 1'b0 || q[3] !== 1'b1);
  endtask
  task automatic ck_st(input [31:0] e);
    apb(8'h10, 1'b0, 32'h0);
    chk(q, e);
  endtask
  // one card cycle, leaves read data in q
  task automatic cyc(input [1:0] sp, input [10:0] a, input [15:0] d, input [2:0] c);
    apb(8'h00, 1'b1, ctrl_v | sp);
    apb(8'h04, 1'b1, {21'h0, a});
    apb(8'h08, 1'b1, {16'h0, d});
    apb(8'h0C, 1'b1, {29'h0, c});
    idle;
    apb(8'h14, 1'b0, 32'h0);
  endtask
  task automatic t_regs;
    idle;
    ck_st(32'h8);
    apb(8'h20, 1'b0, 32'h0);
    chk({sl, q[30:0]}, 32'h80000000);
    $display("test regs done");
  endtask
  task automatic t_attr;
    cyc(2'h0, 11'h200, 16'hFF41, 3'h3);
    ck_st(32'h128);
    cyc(2'h0, 11'h200, 16'h0, 3'h6);
    chk(q, 32'h41);
    cyc(2'h0, 11'h201, 16'h0, 3'h2);
    ck_st(32'h12A);
    cyc(2'h0, 11'h200, 16'h0055, 3'h5);
    ck_st(32'h12A);
    $display("test attr done");
  endtask
  task automatic t_io;
    cyc(2'h1, 11'h004, 16'hBEEF, 3'h7);
    cyc(2'h1, 11'h005, 16'h0, 3'h2);
    chk(q, 32'hBE);
    cyc(2'h1, 11'h004, 16'h0, 3'h2);
    chk(q, 32'hEF);
    cyc(2'h1, 11'h004, 16'h0, 3'h6);
    chk(q, 32'hBEEF);
    cyc(2'h1, 11'h004, 16'h00C4, 3'h5);
    cyc(2'h1, 11'h005, 16'h0, 3'h2);
    chk(q, 32'hC4);
    cyc(2'h1, 11'h004, 16'h0, 3'h4);
    chk(q, 32'hC4);
    cyc(2'h2, 11'h004, 16'h0, 3'h6);
    ck_st(32'h12A);
    $display("test io done");
  endtask
  task automatic t_mem;
    cyc(2'h0, 11'h200, 16'h0, 3'h3);
    cyc(2'h2, 11'h002, 16'h1357, 3'h7);
    cyc(2'h2, 11'h002, 16'h0, 3'h6);
    chk(q, 32'h1357);
    cyc(2'h2, 11'h003, 16'h0, 3'h2);
    chk(q, 32'h13);
    cyc(2'h1, 11'h002, 16'h0, 3'h6);
    ck_st(32'h0A);
    $display("test mem done");
  endtask
  task automatic t_srst;
    cyc(2'h0, 11'h200, 16'h0080, 3'h3);
    ck_st(32'h18);
    apb(8'h00, 1'b1, 32'h20);
    ck_st(32'h08);
    $display("test srst done");
  endtask
  task automatic t_disk;
    ctrl_v = 32'h4;
    apb(8'h00, 1'b1, 32'h14);
    idle;
    ck_st(32'h0C);
    cyc(2'h1, 11'h000, 16'h1234, 3'h3);
    cyc(2'h1, 11'h000, 16'h0, 3'h2);
    chk(q, 32'h1234);
    cyc(2'h1, 11'h003, 16'h0077, 3'h3);
    cyc(2'h1, 11'h003, 16'h0, 3'h2);
    chk(q, 32'h77);
    cyc(2'h1, 11'h006, 16'h005A, 3'h5);
    cyc(2'h1, 11'h006, 16'h0, 3'h4);
    chk(q, 32'h5A);
    cyc(2'h1, 11'h001, 16'h0, 3'h6);
    ck_st(32'h0E);
    cyc(2'h0, 11'h200, 16'h0, 3'h2);
    ck_st(32'h0E);
    ctrl_v = 32'hC;
    cyc(2'h1, 11'h000, 16'h0, 3'h2);
    chk(q, 32'h34);
    $display("test disk done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_attr;
    t_io;
    t_mem;
    t_srst;
    t_disk;
    finish_test;
  end
endmodule // cfh_ctrl_tb
bind cfh_ctrl cfh_ctrl_monitor i_mon (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_card_addr(o_card_addr), .o_low_lane_enable_n(o_low_lane_enable_n),
  .o_high_lane_enable_n(o_high_lane_enable_n), .o_attr_space_n(o_attr_space_n),
  .o_mem_oe_n(o_mem_oe_n), .o_mem_we_n(o_mem_we_n), .o_io_read_strobe_n(o_io_read_strobe_n),
  .o_io_write_strobe_n(o_io_write_strobe_n), .o_card_reset(o_card_reset),
  .o_card_data(o_card_data), .o_card_data_oe_n(o_card_data_oe_n));
`default_nettype wire
